// ===== hw/exbr_regs.sv
// Purpose: exposure bound, observation and stream port registers
// Assumes: serial clock is slow enough to be sampled by clk (8 clk per bit)
// Notes: first byte is write flag plus 7-bit address, data follows
//
// Summary of operation
// - new bounds stay pending until slowest write
// - busy output shows bound update in progress
// - bound reads return last written staged value
// - automatic exposure never exceeds the ceiling
// - ceiling also limits automatic frame interval
// - manual mode uses ceiling as exposure time
// - revision reads zero unless running downloaded firmware
// - frame sets observation bits one and zero
// - bit seven shows downloaded firmware running
// - bit five records a powerdown pin pulse
// - complement register returns inverted part code
// - image port streams one and two-thirds frames
// - movement port streams seven motion bytes
// - download port accepts streamed firmware bytes
// - slowest upper write commits all three pairs
// - new bounds take effect after two frames
`timescale 1ns/10ps
`include "exbr_cfg.svh"
module exbr_regs
  import exbr_pkg::*;
#(
  parameter logic [7:0] PART_CODE = 8'h5A // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic powerdown_n,
  input wire logic frame_tick,
  input wire logic auto_exposure_en,
  input wire logic [15:0] auto_exposure_req,
  input wire logic [15:0] interval_req,
  input wire logic fw_running,
  input wire logic [7:0] fw_revision,
  input wire logic [7:0] motion_flags,
  input wire logic [7:0] delta_x,
  input wire logic [7:0] delta_y,
  input wire logic [7:0] surface_quality,
  input wire logic [7:0] brightest_pixel,
  input wire logic [7:0] pixel_byte,
  output logic pixel_next,
  output logic [15:0] exposure_time,
  output logic [15:0] frame_interval,
  output logic bounds_busy,
  output logic [7:0] fw_data,
  output logic fw_valid,
  input wire logic fw_ready
);
  exbr_state_type s;
  exbr_state_type next_s;
  logic rise;
  logic fall;
  logic active;
  logic pd_fall;
  logic [7:0] sh;
  logic addr_done;
  logic data_done;
  logic commit;
  logic push;
  logic push_ready;
  logic fw_ok;
  logic [15:0] lim;

  // ==================================================================
  // helpers
  function automatic logic [15:0] umin(input logic [15:0] a, input logic [15:0] b);
    umin = (a < b) ? a : b;
  endfunction

  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    sat_add = sum[16] ? 16'hFFFF : sum[15:0];
  endfunction

  function automatic logic is_burst(input logic [6:0] a, input logic w);
    is_burst = w ? (a == `EXBR_ADDR_DOWNLOAD)
                 : (a == `EXBR_ADDR_IMAGE) || (a == `EXBR_ADDR_MOVE);
  endfunction

  function automatic logic [7:0] move_byte(input logic [10:0] idx);
    case (idx)
      11'h000: move_byte = motion_flags;
      11'h001: move_byte = delta_x;
      11'h002: move_byte = delta_y;
      11'h003: move_byte = surface_quality;
      11'h004: move_byte = s.exp_out[15:8];
      11'h005: move_byte = s.exp_out[7:0];
      11'h006: move_byte = brightest_pixel;
      default: move_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] rd_mux(input logic [6:0] a, input logic [10:0] idx);
    case (a)
      `EXBR_ADDR_SLOW_LO: rd_mux = s.slow_lo;
      `EXBR_ADDR_SLOW_HI: rd_mux = s.slow_hi;
      `EXBR_ADDR_FAST_LO: rd_mux = s.fast_lo;
      `EXBR_ADDR_FAST_HI: rd_mux = s.fast_hi;
      `EXBR_ADDR_CEIL_LO: rd_mux = s.ceil_lo;
      `EXBR_ADDR_CEIL_HI: rd_mux = s.ceil_hi;
      `EXBR_ADDR_FW_REV: rd_mux = fw_ok ? fw_revision : 8'h00;
      `EXBR_ADDR_OBS: rd_mux = s.obs_flags | {fw_ok, 7'h00};
      `EXBR_ADDR_PART_INV: rd_mux = ~PART_CODE;
      `EXBR_ADDR_IMAGE: rd_mux = (idx < `EXBR_IMAGE_LEN) ? pixel_byte : 8'h00;
      `EXBR_ADDR_MOVE: rd_mux = move_byte(idx);
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // ==================================================================
  // outputs
  assign fw_ok = fw_running & s.dl_ok;
  assign miso = s.miso;
  assign miso_oe = ~s.sync_ncs[1];
  assign pixel_next = s.pix_next;
  assign exposure_time = s.exp_out;
  assign frame_interval = s.intv_out;
  assign bounds_busy = (s.busy_cnt != 2'd0);

  // ==================================================================
  // firmware buffer
  // a serial master cannot be stalled, so a full buffer spoils the download
  exbr_fifo #(
    .WIDTH(`EXBR_FIFO_WIDTH),
    .DEPTH(`EXBR_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(sh),
    .out_valid(fw_valid),
    .out_ready(fw_ready),
    .out_data(fw_data)
  );

  // ==================================================================
  // next state
  always_comb begin
    next_s = s;
    addr_done = 1'b0;
    data_done = 1'b0;
    commit = 1'b0;
    push = 1'b0;
    next_s.pix_next = 1'b0;
    next_s.sync_sclk = {s.sync_sclk[0], sclk};
    next_s.sync_mosi = {s.sync_mosi[0], mosi};
    next_s.sync_ncs = {s.sync_ncs[0], ncs_n};
    next_s.sync_pd = {s.sync_pd[0], powerdown_n};
    next_s.sclk_d = s.sync_sclk[1];
    next_s.pd_d = s.sync_pd[1];
    rise = s.sync_sclk[1] & ~s.sclk_d;
    fall = ~s.sync_sclk[1] & s.sclk_d;
    active = ~s.sync_ncs[1];
    pd_fall = ~s.sync_pd[1] & s.pd_d;
    sh = {s.shreg[6:0], s.sync_mosi[1]};

    // serial framing
    if (!active) begin
      next_s.phase = EXBR_IDLE;
      next_s.bitcnt = 3'd0;
      if (s.in_dl) begin
        next_s.in_dl = 1'b0;
        next_s.dl_ok = ~s.dl_err;
      end
    end else begin
      case (s.phase)
        EXBR_IDLE: begin
          next_s.phase = EXBR_ADDR;
          next_s.bitcnt = 3'd0;
        end
        EXBR_ADDR, EXBR_DATA: begin
          if (rise) begin
            next_s.shreg = sh;
            next_s.bitcnt = s.bitcnt + 3'd1;
            addr_done = (s.bitcnt == 3'd7) && (s.phase == EXBR_ADDR);
            data_done = (s.bitcnt == 3'd7) && (s.phase == EXBR_DATA);
          end
          if (fall) begin
            next_s.miso = s.tx[7];
            next_s.tx = {s.tx[6:0], 1'b0};
          end
        end
        default: next_s.phase = EXBR_IDLE;
      endcase
    end

    // address byte
    if (addr_done) begin
      next_s.addr = sh[6:0];
      next_s.wr = sh[7];
      next_s.phase = EXBR_DATA;
      next_s.burst_idx = 11'd0;
      if (!sh[7]) begin
        next_s.tx = rd_mux(sh[6:0], 11'd0);
        next_s.pix_next = (sh[6:0] == `EXBR_ADDR_IMAGE);
      end else if (sh[6:0] == `EXBR_ADDR_DOWNLOAD) begin
        next_s.in_dl = 1'b1;
        next_s.dl_err = 1'b0;
        next_s.dl_ok = 1'b0;
      end
    end

    // data byte
    if (data_done) begin
      if (!is_burst(s.addr, s.wr)) begin
        next_s.phase = EXBR_ADDR;
      end
      if (s.wr) begin
        case (s.addr)
          `EXBR_ADDR_SLOW_LO: next_s.slow_lo = sh;
          `EXBR_ADDR_SLOW_HI: begin
            next_s.slow_hi = sh;
            commit = 1'b1;
          end
          `EXBR_ADDR_FAST_LO: next_s.fast_lo = sh;
          `EXBR_ADDR_FAST_HI: next_s.fast_hi = sh;
          `EXBR_ADDR_CEIL_LO: next_s.ceil_lo = sh;
          `EXBR_ADDR_CEIL_HI: next_s.ceil_hi = sh;
          `EXBR_ADDR_OBS: next_s.obs_flags = s.obs_flags & sh & `EXBR_OBS_STICKY_MASK;
          `EXBR_ADDR_DOWNLOAD: begin
            push = s.in_dl;
            if (s.in_dl && !push_ready) begin
              next_s.dl_err = 1'b1;
            end
          end
          default: next_s.wr = s.wr;
        endcase
      end else if (is_burst(s.addr, s.wr)) begin
        next_s.burst_idx = s.burst_idx + 11'd1;
        next_s.tx = rd_mux(s.addr, s.burst_idx + 11'd1);
        next_s.pix_next = (s.addr == `EXBR_ADDR_IMAGE) && (s.burst_idx + 11'd1 < `EXBR_IMAGE_LEN);
      end
    end

    // bound commit, applied two frames later
    if (commit) begin
      next_s.snap_slow = {sh, s.slow_lo};
      next_s.snap_fast = {s.fast_hi, s.fast_lo};
      next_s.snap_ceil = {s.ceil_hi, s.ceil_lo};
      next_s.busy_cnt = `EXBR_BUSY_FRAMES;
    end else if (frame_tick && (s.busy_cnt != 2'd0)) begin
      next_s.busy_cnt = s.busy_cnt - 2'd1;
      if (s.busy_cnt == 2'd1) begin
        next_s.app_slow = s.snap_slow;
        next_s.app_fast = s.snap_fast;
        next_s.app_ceil = s.snap_ceil;
      end
    end

    // sticky flags; a set in the clearing cycle wins
    if (frame_tick) begin
      next_s.obs_flags = next_s.obs_flags | `EXBR_OBS_TICK_MASK;
    end
    if (pd_fall) begin
      next_s.obs_flags[`EXBR_OBS_PD] = 1'b1;
    end

    // exposure and interval selection
    lim = umin(s.app_slow, sat_add(s.app_fast, s.app_ceil));
    next_s.intv_out = umin(interval_req, lim);
    if (next_s.intv_out < s.app_fast) begin
      next_s.intv_out = s.app_fast;
    end
    if (auto_exposure_en) begin
      next_s.exp_out = umin(auto_exposure_req, s.app_ceil);
    end else begin
      next_s.exp_out = s.app_ceil;
    end
  end

  // ==================================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.phase <= EXBR_IDLE;
      s.sync_sclk <= 2'b11;
      s.sclk_d <= 1'b1;
      s.sync_ncs <= 2'b11;
      s.sync_pd <= 2'b11;
      s.pd_d <= 1'b1;
      s.slow_lo <= `EXBR_RST_SLOW_LO;
      s.slow_hi <= `EXBR_RST_SLOW_HI;
      s.fast_lo <= `EXBR_RST_FAST_LO;
      s.fast_hi <= `EXBR_RST_FAST_HI;
      s.ceil_lo <= `EXBR_RST_CEIL_LO;
      s.ceil_hi <= `EXBR_RST_CEIL_HI;
      s.app_slow <= {`EXBR_RST_SLOW_HI, `EXBR_RST_SLOW_LO};
      s.app_fast <= {`EXBR_RST_FAST_HI, `EXBR_RST_FAST_LO};
      s.app_ceil <= {`EXBR_RST_CEIL_HI, `EXBR_RST_CEIL_LO};
      s.obs_flags <= `EXBR_RST_OBS;
    end else begin
      s <= next_s;
    end
  end

  // ==================================================================
  // checks
  property p_pending_hold;
    @(posedge clk) disable iff (!rst_n)
    $changed(s.app_ceil) |-> $past(s.busy_cnt) == 2'd1 && $past(frame_tick);
  endproperty
  a_pending_hold: assert property (p_pending_hold) else $error("ceiling applied early");
  property p_commit;
    @(posedge clk) disable iff (!rst_n)
    commit |=> s.busy_cnt == 2'd2 && s.snap_ceil == {s.ceil_hi, s.ceil_lo};
  endproperty
  a_commit: assert property (p_commit) else $error("commit did not stage bounds");
  property p_apply;
    @(posedge clk) disable iff (!rst_n)
    (frame_tick && !commit && s.busy_cnt == 2'd1) |=> s.app_fast == $past(s.snap_fast)
      && !bounds_busy;
  endproperty
  a_apply: assert property (p_apply) else $error("bounds not applied after two frames");
  property p_auto_cap;
    @(posedge clk) disable iff (!rst_n)
    auto_exposure_en |=> s.exp_out <= $past(s.app_ceil);
  endproperty
  a_auto_cap: assert property (p_auto_cap) else $error("exposure above ceiling");
  property p_manual;
    @(posedge clk) disable iff (!rst_n)
    !auto_exposure_en |=> s.exp_out == $past(s.app_ceil);
  endproperty
  a_manual: assert property (p_manual) else $error("manual exposure differs");
  property p_interval;
    @(posedge clk) disable iff (!rst_n)
    $past(s.app_slow) >= $past(s.app_fast) |->
      {1'b0, s.intv_out} <= {1'b0, $past(s.app_fast)} + {1'b0, $past(s.app_ceil)};
  endproperty
  a_interval: assert property (p_interval) else $error("interval beyond ceiling");
  property p_tick_flags;
    @(posedge clk) disable iff (!rst_n)
    frame_tick |=> s.obs_flags[1:0] == 2'b11;
  endproperty
  a_tick_flags: assert property (p_tick_flags) else $error("frame flags not set");
  property p_pd_flag;
    @(posedge clk) disable iff (!rst_n)
    pd_fall |=> s.obs_flags[`EXBR_OBS_PD] ##1 s.obs_flags[`EXBR_OBS_PD] || $past(data_done);
  endproperty
  a_pd_flag: assert property (p_pd_flag) else $error("powerdown pulse lost");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
    (s.obs_flags & ~`EXBR_OBS_STICKY_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved flag set");

  property p_part_inv;
    @(posedge clk) disable iff (!rst_n)
    (addr_done && sh == {1'b0, `EXBR_ADDR_PART_INV}) |=> s.tx == ~PART_CODE;
  endproperty
  a_part_inv: assert property (p_part_inv) else $error("bad part code complement");
endmodule

// ===== hw/exbr_cfg.svh
// Purpose: constants of the exposure bound and observation register bank
// Assumes: 7-bit register addresses on the four-wire serial port
// Notes: staged bounds reset to their pre-download values
`ifndef EXBR_CFG_SVH
`define EXBR_CFG_SVH

// ==================================================================
// register addresses
`define EXBR_ADDR_SLOW_LO 7'h19
`define EXBR_ADDR_SLOW_HI 7'h1A
`define EXBR_ADDR_FAST_LO 7'h1B
`define EXBR_ADDR_FAST_HI 7'h1C
`define EXBR_ADDR_CEIL_LO 7'h1D
`define EXBR_ADDR_CEIL_HI 7'h1E
`define EXBR_ADDR_FW_REV 7'h1F
`define EXBR_ADDR_OBS 7'h3D
`define EXBR_ADDR_PART_INV 7'h3F
`define EXBR_ADDR_IMAGE 7'h40
`define EXBR_ADDR_MOVE 7'h50
`define EXBR_ADDR_DOWNLOAD 7'h60

// ==================================================================
// reset values
`define EXBR_RST_SLOW_LO 8'hE0
`define EXBR_RST_SLOW_HI 8'h2E
`define EXBR_RST_FAST_LO 8'hAC
`define EXBR_RST_FAST_HI 8'h0D
`define EXBR_RST_CEIL_LO 8'h8C
`define EXBR_RST_CEIL_HI 8'h20
`define EXBR_RST_OBS 8'h00

// ==================================================================
// observation fields
`define EXBR_OBS_RUN 7
`define EXBR_OBS_PD 5
`define EXBR_OBS_TICK_MASK 8'h03
`define EXBR_OBS_STICKY_MASK 8'h23

// ==================================================================
// timing, burst lengths and buffer size
`define EXBR_BUSY_FRAMES 2'd2
`define EXBR_IMAGE_LEN 11'd1500
`define EXBR_MOVE_LEN 11'd7
`define EXBR_FIFO_DEPTH 8
`define EXBR_FIFO_WIDTH 8

`endif

// ===== hw/exbr_pkg.sv
// Purpose: types of the exposure bound and observation register bank
// Assumes: constants come from exbr_cfg.svh
// Notes: one packed struct holds all state of the main module
package exbr_pkg;

  typedef enum logic [2:0] {
    EXBR_IDLE = 3'b001,
    EXBR_ADDR = 3'b010,
    EXBR_DATA = 3'b100
  } exbr_phase_type;

  typedef struct packed {
    logic [1:0] sync_sclk;
    logic [1:0] sync_mosi;
    logic [1:0] sync_ncs;
    logic [1:0] sync_pd;
    logic sclk_d;
    logic pd_d;
    exbr_phase_type phase;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [6:0] addr;
    logic wr;
    logic [10:0] burst_idx;
    logic miso;
    logic [7:0] slow_lo;
    logic [7:0] slow_hi;
    logic [7:0] fast_lo;
    logic [7:0] fast_hi;
    logic [7:0] ceil_lo;
    logic [7:0] ceil_hi;
    logic [15:0] snap_slow;
    logic [15:0] snap_fast;
    logic [15:0] snap_ceil;
    logic [15:0] app_slow;
    logic [15:0] app_fast;
    logic [15:0] app_ceil;
    logic [1:0] busy_cnt;
    logic [7:0] obs_flags;
    logic in_dl;
    logic dl_err;
    logic dl_ok;
    logic [15:0] exp_out;
    logic [15:0] intv_out;
    logic pix_next;
  } exbr_state_type;

endpackage

// ===== hw/exbr_fifo.sv
// Purpose: firmware byte buffer between serial port and loader
// Assumes: DEPTH is a power of two
// Notes: full and empty from pointers with one extra wrap bit
`timescale 1ns/10ps
module exbr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } exbr_fifo_state_type;

  exbr_fifo_state_type s;
  exbr_fifo_state_type next_s;
  logic [AW:0] fill;

  // ==================================================================
  // flags
  assign fill = s.wp - s.rp;
  assign in_ready = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != '0);
  assign out_data = s.mem[s.rp[AW-1:0]];

  // ==================================================================
  // pointers and storage
  always_comb begin
    next_s = s;
    if (in_valid && in_ready) begin
      next_s.mem[s.wp[AW-1:0]] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ===== tb/exbr_host.sv
// Purpose: serial port master model for the register bank
// Assumes: 8 clk per serial bit, sclk idle high, bits MSB first
// Notes: mosi flips to the inverse of its last bit outside frames
`timescale 1ns/10ps
module exbr_host (
  input wire logic clk,
  output logic ncs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  initial begin
    ncs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end

  // ==================================================================
  // frame and byte tasks
  task automatic open_frame();
    @(posedge clk) #1 ncs_n = 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic close_frame();
    repeat (4) @(posedge clk);
    #1 ncs_n = 1'b1;
    // released line must not keep looking valid
    mosi = ~mosi;
    repeat (6) @(posedge clk);
  endtask

  // miso is taken at the rising sclk edge, after the device had half a bit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) #1 sclk = 1'b0;
      mosi = tx[i];
      repeat (4) @(posedge clk);
      #1 rx[i] = miso;
      sclk = 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic reg_write(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] rx;
    open_frame();
    xfer({1'b1, addr}, rx);
    xfer(data, rx);
    close_frame();
  endtask

  task automatic reg_read(input logic [6:0] addr, output logic [7:0] data);
    logic [7:0] rx;
    open_frame();
    xfer({1'b0, addr}, rx);
    xfer(8'h00, data);
    close_frame();
  endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the exposure bound register bank
// Assumes: frame tick every 64 clk, serial master in exbr_host
// Notes: image burst checked on a few pixels only, full length is too slow
`timescale 1ns/10ps
`include "exbr_cfg.svh"
module tb_top;
  localparam logic [7:0] PART = 8'h5A; // arbitrary value
  localparam logic [7:0] REV = 8'h3C; // arbitrary value
  logic clk, rst_n, ncs_n, sclk, mosi, miso, miso_oe, powerdown_n, frame_tick = 1'b0;
  logic auto_en, fw_running, pixel_next, bounds_busy, fw_valid, fw_ready, tick_en;
  logic [15:0] auto_req, interval_req, exposure_time, frame_interval;
  logic [7:0] pixel_byte = 8'h10, fw_data, rd, pix0;
  logic [7:0] mv [8];
  logic [7:0] fw_q [$];
  int fails, check_count, busy_ticks = 0, tick_cnt = 0;

  exbr_host host (.clk(clk), .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi), .miso(miso));

  exbr_regs #(.PART_CODE(PART)) uut (
    .clk(clk), .rst_n(rst_n), .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .powerdown_n(powerdown_n), .frame_tick(frame_tick),
    .auto_exposure_en(auto_en), .auto_exposure_req(auto_req), .interval_req(interval_req),
    .fw_running(fw_running), .fw_revision(REV), .motion_flags(mv[0]), .delta_x(mv[1]),
    .delta_y(mv[2]), .surface_quality(mv[3]), .brightest_pixel(mv[6]),
    .pixel_byte(pixel_byte), .pixel_next(pixel_next), .exposure_time(exposure_time),
    .frame_interval(frame_interval), .bounds_busy(bounds_busy), .fw_data(fw_data),
    .fw_valid(fw_valid), .fw_ready(fw_ready)
  );

  // ==================================================================
  // clock, frame source, pixel source, loader
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    tick_cnt <= (tick_cnt == 63) ? 0 : tick_cnt + 1;
    frame_tick <= #1 tick_en && (tick_cnt == 63);
    if (pixel_next) pixel_byte <= #1 pixel_byte + 8'h01;
    if (bounds_busy && frame_tick) busy_ticks <= busy_ticks + 1;
    if (fw_valid && fw_ready) fw_q.push_back(fw_data);
  end

  // ==================================================================
  // checking tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp, input string what);
    logic [7:0] got;
    host.reg_read(addr, got);
    chk(what, {8'h00, exp}, {8'h00, got});
  endtask

  task automatic download(input int n);
    host.open_frame();
    host.xfer({1'b1, `EXBR_ADDR_DOWNLOAD}, rd);
    for (int i = 0; i < n; i++) host.xfer(8'hC0 + 8'(i), rd);
    host.close_frame();
  endtask

  task automatic summarize();
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    summarize();
  end

  // ==================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    powerdown_n = 1'b1;
    auto_en = 1'b0;
    auto_req = 16'hFFFF;
    interval_req = 16'hFFFF;
    fw_running = 1'b0;
    fw_ready = 1'b0;
    tick_en = 1'b1;
    mv = '{8'h81, 8'h05, 8'hFB, 8'h40, 8'h01, 8'h00, 8'hEE, 8'h00};
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(`EXBR_ADDR_SLOW_LO, `EXBR_RST_SLOW_LO, "slow_lo");
    rd_chk(`EXBR_ADDR_SLOW_HI, `EXBR_RST_SLOW_HI, "slow_hi");
    rd_chk(`EXBR_ADDR_FAST_LO, `EXBR_RST_FAST_LO, "fast_lo");
    rd_chk(`EXBR_ADDR_FAST_HI, `EXBR_RST_FAST_HI, "fast_hi");
    rd_chk(`EXBR_ADDR_CEIL_HI, `EXBR_RST_CEIL_HI, "ceil_hi");
    rd_chk(`EXBR_ADDR_CEIL_LO, `EXBR_RST_CEIL_LO, "ceil_lo");
    rd_chk(`EXBR_ADDR_FW_REV, 8'h00, "revision idle");
    rd_chk(`EXBR_ADDR_PART_INV, ~PART, "part complement");
    rd_chk(7'h3E, 8'h00, "unmapped");
    host.reg_write(`EXBR_ADDR_PART_INV, 8'h00);
    rd_chk(`EXBR_ADDR_PART_INV, ~PART, "complement kept");
    chk("exposure reset", {`EXBR_RST_CEIL_HI, `EXBR_RST_CEIL_LO}, exposure_time);
    host.reg_write(`EXBR_ADDR_CEIL_LO, 8'h34);
    host.reg_write(`EXBR_ADDR_CEIL_HI, 8'h12);
    host.reg_write(`EXBR_ADDR_FAST_LO, 8'h00);
    host.reg_write(`EXBR_ADDR_FAST_HI, 8'h0E);
    rd_chk(`EXBR_ADDR_CEIL_HI, 8'h12, "staged hi");
    rd_chk(`EXBR_ADDR_CEIL_LO, 8'h34, "staged lo");
    rd_chk(`EXBR_ADDR_FAST_HI, 8'h0E, "staged fast");
    chk("pending exposure", 16'h208C, exposure_time);
    chk("pending interval", 16'h2E38, frame_interval);
    host.reg_write(`EXBR_ADDR_SLOW_LO, `EXBR_RST_SLOW_LO);
    host.reg_write(`EXBR_ADDR_SLOW_HI, `EXBR_RST_SLOW_HI);
    chk("busy", 16'h0001, {15'h0000, bounds_busy});
    for (int i = 0; i < 400 && bounds_busy !== 1'b0; i++) @(posedge clk) #1;
    if (bounds_busy !== 1'b0) begin
      fails++;
      summarize();
    end
    repeat (2) @(posedge clk);
    chk("busy frames", 16'h0002, busy_ticks[15:0]);
    chk("manual exposure", 16'h1234, exposure_time);
    @(posedge clk) #1 auto_en = 1'b1;
    repeat (3) @(posedge clk);
    chk("auto ceiling", 16'h1234, exposure_time);
    chk("interval ceiling", 16'h2034, frame_interval);
    @(posedge clk) #1 auto_req = 16'h0100;
    interval_req = 16'h0001;
    repeat (3) @(posedge clk);
    chk("auto exposure", 16'h0100, exposure_time);
    chk("interval floor", 16'h0E00, frame_interval);
    host.open_frame();
    chk("miso_oe active", 16'h0001, {15'h0000, miso_oe});
    host.xfer({1'b0, `EXBR_ADDR_MOVE}, rd);
    for (int i = 0; i < 8; i++) begin
      host.xfer(8'h00, rd);
      chk("movement byte", {8'h00, mv[i]}, {8'h00, rd});
    end
    host.close_frame();
    chk("miso_oe idle", 16'h0000, {15'h0000, miso_oe});
    host.open_frame();
    host.xfer({1'b0, `EXBR_ADDR_IMAGE}, rd);
    host.xfer(8'h00, pix0);
    for (int i = 1; i < 4; i++) begin
      host.xfer(8'h00, rd);
      chk("pixel", {8'h00, pix0 + 8'(i)}, {8'h00, rd});
    end
    host.close_frame();
    // ticks off so the flags hold what was written
    @(posedge clk) #1 tick_en = 1'b0;
    host.reg_write(`EXBR_ADDR_OBS, 8'h00);
    rd_chk(`EXBR_ADDR_OBS, 8'h00, "flags cleared");
    @(posedge clk) #1 powerdown_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 powerdown_n = 1'b1;
    tick_en = 1'b1;
    repeat (70) @(posedge clk);
    #1 tick_en = 1'b0;
    rd_chk(`EXBR_ADDR_OBS, 8'h23, "flags set");
    host.reg_write(`EXBR_ADDR_OBS, 8'hFF);
    rd_chk(`EXBR_ADDR_OBS, 8'h23, "reserved flags");
    host.reg_write(`EXBR_ADDR_OBS, 8'h00);
    @(posedge clk) #1 fw_running = 1'b1;
    download(9);
    @(posedge clk) #1 fw_ready = 1'b1;
    repeat (12) @(posedge clk);
    rd_chk(`EXBR_ADDR_FW_REV, 8'h00, "revision after overflow");
    rd_chk(`EXBR_ADDR_OBS, 8'h00, "no running flag");
    @(posedge clk) #1 fw_ready = 1'b0;
    fw_q.delete();
    download(8);
    @(posedge clk) #1 fw_ready = 1'b1;
    repeat (12) @(posedge clk);
    chk("firmware count", 16'd8, 16'(fw_q.size()));
    for (int i = 0; i < 8; i++) begin
      chk("firmware byte", {8'h00, 8'hC0 + 8'(i)}, {8'h00, fw_q[i]});
    end
    rd_chk(`EXBR_ADDR_FW_REV, REV, "revision");
    rd_chk(`EXBR_ADDR_OBS, 8'h80, "running flag");
    summarize();
  end
endmodule
